/* shared/lpw_pkg.sv */
// package: constants, types and vector map of the low-power wake controller
package lpw_pkg;
   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] VECTOR_OFFSET = 4'h8;
   // control field positions
   localparam int CTRL_SHORT_REC_BIT = 0;
   localparam int CTRL_KBD_MASK_BIT = 1;
   localparam int CTRL_LVD_EN_BIT = 2;
   localparam int CTRL_LVD_RST_BIT = 3;
   localparam int CTRL_EXT_INTERRUPT_PIN_FIRST_MASK_BIT = 4;
   localparam int CTRL_EXT_INTERRUPT_PIN_SECOND_MASK_BIT = 5;
   localparam int CTRL_WIDTH = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // status field positions
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_BY_RESET_BIT = 2;
   // ----------------------------------------------------------------
   // stop recovery, in crystal cycles
   // ----------------------------------------------------------------
   localparam int REC_FULL_CYC = 4096;
   localparam int REC_SHORT_CYC = 32;
   localparam int REC_CNT_W = 12;
   localparam logic [11:0] REC_CNT_RESET = 12'h000;
   // ----------------------------------------------------------------
   // wake vectors, high byte address of each pair
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_BREAK = 16'hFFFC;
   localparam logic [15:0] VEC_EXT_INTERRUPT_PIN_FIRST = 16'hFFFA;
   localparam logic [15:0] VEC_PLL = 16'hFFF8;
   localparam logic [15:0] VEC_DMA = 16'hFFF6;
   localparam logic [15:0] VEC_TIM_CH0 = 16'hFFF4;
   localparam logic [15:0] VEC_TIM_CH1 = 16'hFFF2;
   localparam logic [15:0] VEC_TIM_CH2 = 16'hFFF0;
   localparam logic [15:0] VEC_TIM_CH3 = 16'hFFEE;
   localparam logic [15:0] VEC_TIM_OVF = 16'hFFEC;
   localparam logic [15:0] VEC_SSU_RX = 16'hFFEA;
   localparam logic [15:0] VEC_SSU_TX = 16'hFFE8;
   localparam logic [15:0] VEC_ASU_ERR = 16'hFFE6;
   localparam logic [15:0] VEC_ASU_RX = 16'hFFE4;
   localparam logic [15:0] VEC_ASU_TX = 16'hFFE2;
   localparam logic [15:0] VEC_EXT_INTERRUPT_PIN_SECOND = 16'hFFE0;
   localparam logic [15:0] VEC_KBD = 16'hFFDE;
   localparam logic [15:0] VEC_RESET_VAL = 16'h0000;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_WAIT,
      ST_STOP,
      ST_RECOVER
   } lpw_state_t;
   // enabled processor interrupt requests from the bus-clocked units
   typedef struct packed {
      logic pll;
      logic dma;
      logic tim_ovf;
      logic [3:0] tim_ch;
      logic ssu_tx;
      logic ssu_rx;
      logic asu_tx;
      logic asu_rx;
      logic asu_err;
   } lpw_irq_t;
   // clock gates and unit controls
   typedef struct packed {
      logic cpu_clk_en;
      logic bus_clk_en;
      logic asu_halt;
      logic ssu_halt;
      logic ssu_reset;
      logic tim_freeze;
      logic kbd_run;
      logic lvd_run;
   } lpw_gate_t;
endpackage

/* hdl/lpw_wake_ctrl.sv */
// low-power wake controller: wait/stop entry, wake sources, stop recovery
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module lpw_wake_ctrl #(
   parameter int REC_FULL = lpw_pkg::REC_FULL_CYC,
   parameter int REC_SHORT = lpw_pkg::REC_SHORT_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins, asynchronous
   input wire logic reset_pin_n,
   input wire logic ext_interrupt_pin_first,
   input wire logic ext_interrupt_pin_second,
   input wire logic supply_low,
   // core and units, same clock
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic break_req,
   input wire logic watchdog_timeout,
   input wire logic keypad_req,
   input wire lpw_pkg::lpw_irq_t unit_irq,
   // to core and units
   output lpw_pkg::lpw_gate_t gate,
   output logic sys_reset,
   output logic vector_valid,
   output logic [15:0] wake_vector
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam logic [11:0] TERM_FULL = 12'(REC_FULL - 1);
   localparam logic [11:0] TERM_SHORT = 12'(REC_SHORT - 1);
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [1:0] irq_prev_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_reg <= 4'h7;
         pin_s2_reg <= 4'h7;
         irq_prev_reg <= 2'h3;
      end else begin
         pin_s1_reg <= {supply_low, ext_interrupt_pin_second,
                        ext_interrupt_pin_first, reset_pin_n};
         pin_s2_reg <= pin_s1_reg;
         irq_prev_reg <= pin_s2_reg[2:1];
      end
   end
   // ----------------------------------------------------------------
   // control register and wake events
   // ----------------------------------------------------------------
   logic [5:0] ctrl_reg;
   lpw_pkg::lpw_state_t state_reg;
   logic ssr;
   logic kbd_mask;
   logic lvd_en;
   logic lvd_rst;
   logic ext_interrupt_pin_first_fall;
   logic ext_interrupt_pin_second_fall;
   logic kbd_evt;
   logic lvd_evt;
   logic reset_evt;
   logic ext_evt;
   logic periph_evt;
   logic stop_wake;
   logic wait_wake;
   assign ssr = ctrl_reg[lpw_pkg::CTRL_SHORT_REC_BIT];
   assign kbd_mask = ctrl_reg[lpw_pkg::CTRL_KBD_MASK_BIT];
   assign lvd_en = ctrl_reg[lpw_pkg::CTRL_LVD_EN_BIT];
   assign lvd_rst = ctrl_reg[lpw_pkg::CTRL_LVD_RST_BIT];
   // falling edges, gated by the pin masks
   assign ext_interrupt_pin_first_fall = irq_prev_reg[0] & ~pin_s2_reg[1]
                      & ~ctrl_reg[lpw_pkg::CTRL_EXT_INTERRUPT_PIN_FIRST_MASK_BIT];
   assign ext_interrupt_pin_second_fall = irq_prev_reg[1] & ~pin_s2_reg[2]
                      & ~ctrl_reg[lpw_pkg::CTRL_EXT_INTERRUPT_PIN_SECOND_MASK_BIT];
   assign kbd_evt = keypad_req & ~kbd_mask;
   assign lvd_evt = pin_s2_reg[3] & lvd_en & lvd_rst;
   // watchdog is a reset source in every state but stop, where it is unclocked
   assign reset_evt = ~pin_s2_reg[0] | lvd_evt
                      | (watchdog_timeout
                         & (state_reg != lpw_pkg::ST_STOP));
   assign ext_evt = ext_interrupt_pin_first_fall | ext_interrupt_pin_second_fall | kbd_evt | break_req;
   assign periph_evt = |unit_irq;
   // halted units cannot end stop
   assign stop_wake = reset_evt | ext_evt;
   assign wait_wake = stop_wake | periph_evt;
   // ----------------------------------------------------------------
   // vector selection, resets first
   // ----------------------------------------------------------------
   logic unit_gate;
   lpw_pkg::lpw_irq_t live_irq;
   assign unit_gate = state_reg == lpw_pkg::ST_RUN
                      || state_reg == lpw_pkg::ST_WAIT;
   // halted units must not steer the vector of a stop wake
   assign live_irq = lpw_pkg::lpw_irq_t'(unit_irq & {12{unit_gate}});
   logic [15:0] vec_sel;
   always_comb begin
      vec_sel = lpw_pkg::VEC_RESET;
      if (reset_evt) vec_sel = lpw_pkg::VEC_RESET;
      else if (break_req) vec_sel = lpw_pkg::VEC_BREAK;
      else if (ext_interrupt_pin_first_fall) vec_sel = lpw_pkg::VEC_EXT_INTERRUPT_PIN_FIRST;
      else if (live_irq.pll) vec_sel = lpw_pkg::VEC_PLL;
      else if (live_irq.dma) vec_sel = lpw_pkg::VEC_DMA;
      else if (live_irq.tim_ch[0]) vec_sel = lpw_pkg::VEC_TIM_CH0;
      else if (live_irq.tim_ch[1]) vec_sel = lpw_pkg::VEC_TIM_CH1;
      else if (live_irq.tim_ch[2]) vec_sel = lpw_pkg::VEC_TIM_CH2;
      else if (live_irq.tim_ch[3]) vec_sel = lpw_pkg::VEC_TIM_CH3;
      else if (live_irq.tim_ovf) vec_sel = lpw_pkg::VEC_TIM_OVF;
      else if (live_irq.ssu_rx) vec_sel = lpw_pkg::VEC_SSU_RX;
      else if (live_irq.ssu_tx) vec_sel = lpw_pkg::VEC_SSU_TX;
      else if (live_irq.asu_err) vec_sel = lpw_pkg::VEC_ASU_ERR;
      else if (live_irq.asu_rx) vec_sel = lpw_pkg::VEC_ASU_RX;
      else if (live_irq.asu_tx) vec_sel = lpw_pkg::VEC_ASU_TX;
      else if (ext_interrupt_pin_second_fall) vec_sel = lpw_pkg::VEC_EXT_INTERRUPT_PIN_SECOND;
      else if (kbd_evt) vec_sel = lpw_pkg::VEC_KBD;
   end
   // ----------------------------------------------------------------
   // mode state machine and recovery counter
   // ----------------------------------------------------------------
   logic [11:0] rec_cnt_reg;
   logic [11:0] rec_term;
   logic by_reset_reg;
   logic rec_done;
   assign rec_term = ssr ? TERM_SHORT : TERM_FULL;
   assign rec_done = (rec_cnt_reg == rec_term) & ~stop_wake;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= lpw_pkg::ST_RUN;
      end else begin
         case (state_reg)
            lpw_pkg::ST_RUN: begin
               if (stop_exec) state_reg <= lpw_pkg::ST_STOP;
               else if (wait_exec) state_reg <= lpw_pkg::ST_WAIT;
            end
            lpw_pkg::ST_WAIT: begin
               if (wait_wake) state_reg <= lpw_pkg::ST_RUN;
            end
            lpw_pkg::ST_STOP: begin
               if (stop_wake) state_reg <= lpw_pkg::ST_RECOVER;
            end
            lpw_pkg::ST_RECOVER: begin
               if (rec_done) state_reg <= lpw_pkg::ST_RUN;
            end
            default: state_reg <= lpw_pkg::ST_RUN;
         endcase
      end
   end
   // counts crystal cycles; aclk is the crystal clock here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rec_cnt_reg <= lpw_pkg::REC_CNT_RESET;
      end else if (stop_wake && (state_reg == lpw_pkg::ST_STOP
                   || state_reg == lpw_pkg::ST_RECOVER)) begin
         rec_cnt_reg <= lpw_pkg::REC_CNT_RESET;
      end else if (state_reg == lpw_pkg::ST_RECOVER && !rec_done) begin
         rec_cnt_reg <= rec_cnt_reg + 12'h0001;
      end
   end
   // ----------------------------------------------------------------
   // vector, reset and unit outputs
   // ----------------------------------------------------------------
   logic take_wake;
   logic ssu_rst_reg;
   assign take_wake = (state_reg == lpw_pkg::ST_WAIT && wait_wake)
                      || (state_reg == lpw_pkg::ST_STOP && stop_wake)
                      || (state_reg == lpw_pkg::ST_RECOVER && stop_wake);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_vector <= lpw_pkg::VEC_RESET_VAL;
         by_reset_reg <= 1'b0;
         sys_reset <= 1'b0;
         ssu_rst_reg <= 1'b0;
      end else begin
         if (take_wake || reset_evt) begin
            wake_vector <= vec_sel;
            by_reset_reg <= reset_evt;
         end
         sys_reset <= reset_evt;
         // transfer in progress is dropped when stop ends through reset
         ssu_rst_reg <= reset_evt
                           && state_reg != lpw_pkg::ST_RUN
                           && state_reg != lpw_pkg::ST_WAIT;
      end
   end
   // vector handed to the core when its clock comes back
   always_ff @(posedge aclk) begin
      if (!aresetn) vector_valid <= 1'b0;
      else vector_valid <= (state_reg == lpw_pkg::ST_WAIT && wait_wake)
                           || (state_reg == lpw_pkg::ST_RECOVER && rec_done);
   end
   logic stopped;
   assign stopped = (state_reg == lpw_pkg::ST_STOP)
                    || (state_reg == lpw_pkg::ST_RECOVER);
   assign gate.cpu_clk_en = (state_reg == lpw_pkg::ST_RUN);
   assign gate.bus_clk_en = ~stopped;
   assign gate.asu_halt = stopped;
   assign gate.ssu_halt = stopped;
   assign gate.ssu_reset = ssu_rst_reg;
   assign gate.tim_freeze = stopped;
   assign gate.kbd_run = 1'b1;
   assign gate.lvd_run = lvd_en;
   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic wr_take;
   logic rd_take;
   assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign rd_take = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = rd_take;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= lpw_pkg::CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr[3:2] == lpw_pkg::CTRL_OFFSET[3:2]) begin
               s_axi_bresp <= 2'b00;
               if (s_axi_wstrb[0]) ctrl_reg <= s_axi_wdata[5:0];
            end else if (s_axi_awaddr[3:2] == lpw_pkg::STATUS_OFFSET[3:2]
                      || s_axi_awaddr[3:2] == lpw_pkg::VECTOR_OFFSET[3:2])
            begin
               s_axi_bresp <= 2'b00;
            end else begin
               s_axi_bresp <= 2'b10;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr[3:2])
            lpw_pkg::CTRL_OFFSET[3:2]:
               s_axi_rdata <= {26'h000_0000, ctrl_reg};
            lpw_pkg::STATUS_OFFSET[3:2]:
               s_axi_rdata <= {29'h0000_0000, by_reset_reg, state_reg};
            lpw_pkg::VECTOR_OFFSET[3:2]:
               s_axi_rdata <= {16'h0000, wake_vector};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_wait_clocks;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_WAIT |-> !gate.cpu_clk_en && gate.bus_clk_en;
   endproperty
   a_wait_clocks: assert property (p_wait_clocks)
      else $error("wait clocks wrong");
   property p_stop_clocks;
      @(posedge aclk) disable iff (!aresetn)
      stop_exec && state_reg == lpw_pkg::ST_RUN
      |=> !gate.bus_clk_en && !gate.cpu_clk_en && gate.tim_freeze;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks)
      else $error("stop did not gate clocks");
   property p_stop_ignores_units;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_STOP && periph_evt && !stop_wake
      |=> state_reg == lpw_pkg::ST_STOP;
   endproperty
   a_stop_ignores_units: assert property (p_stop_ignores_units)
      else $error("unit request ended stop");
   property p_kbd_wait;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_WAIT && keypad_req && !kbd_mask
      |=> state_reg == lpw_pkg::ST_RUN && vector_valid;
   endproperty
   a_kbd_wait: assert property (p_kbd_wait)
      else $error("keypad did not end wait");
   property p_kbd_stop;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_STOP && keypad_req && !kbd_mask && !reset_evt
      && !break_req && !ext_interrupt_pin_first_fall && !ext_interrupt_pin_second_fall
      |=> state_reg == lpw_pkg::ST_RECOVER && wake_vector == lpw_pkg::VEC_KBD;
   endproperty
   a_kbd_stop: assert property (p_kbd_stop)
      else $error("keypad stop wake wrong");
   property p_reset_vec;
      @(posedge aclk) disable iff (!aresetn)
      reset_evt |=> sys_reset && wake_vector == lpw_pkg::VEC_RESET;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("reset vector wrong");
   property p_ssu_reset;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_STOP && reset_evt |=> gate.ssu_reset;
   endproperty
   a_ssu_reset: assert property (p_ssu_reset)
      else $error("sync serial not reset");
   property p_dma_vec;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_WAIT && unit_irq.dma && !stop_wake
      && !unit_irq.pll |=> wake_vector == lpw_pkg::VEC_DMA && vector_valid;
   endproperty
   a_dma_vec: assert property (p_dma_vec)
      else $error("transfer engine vector wrong");
   property p_rec_reload;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_RECOVER && stop_wake |=> rec_cnt_reg == 12'h000
      && state_reg == lpw_pkg::ST_RECOVER;
   endproperty
   a_rec_reload: assert property (p_rec_reload)
      else $error("recovery counter not reloaded");
   property p_rec_short;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_RECOVER && ssr && rec_cnt_reg == TERM_SHORT
      && !stop_wake |=> gate.cpu_clk_en && vector_valid;
   endproperty
   a_rec_short: assert property (p_rec_short)
      else $error("short recovery release wrong");
   property p_rec_full_hold;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_RECOVER && !ssr && rec_cnt_reg < TERM_FULL
      |=> !gate.bus_clk_en;
   endproperty
   a_rec_full_hold: assert property (p_rec_full_hold)
      else $error("full recovery released early");
   c_wait_wake: cover property (@(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_WAIT ##1 state_reg == lpw_pkg::ST_RUN);
   c_stop_recover: cover property (@(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_RECOVER ##1 state_reg == lpw_pkg::ST_RUN);
   c_short_rec: cover property (@(posedge aclk) disable iff (!aresetn)
      state_reg == lpw_pkg::ST_RECOVER && ssr && rec_done);
endmodule

/* bench/lpw_core_model.sv */
// partner model: core and peripherals raising wake requests
`timescale 1ns/1ps
module lpw_core_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench commands and service
   input wire logic go,
   input wire logic [3:0] cmd,
   input wire logic [11:0] irq_sel,
   input wire logic vector_valid,
   // requests to the controller
   output logic wait_exec,
   output logic stop_exec,
   output logic break_req,
   output logic keypad_req,
   output logic watchdog_timeout,
   output lpw_pkg::lpw_irq_t unit_irq
);
   // pulses only: a held stop wake would keep reloading recovery
   always_ff @(posedge aclk) begin
      wait_exec <= aresetn && go && cmd == 4'h1;
      stop_exec <= aresetn && go && cmd == 4'h2;
      break_req <= aresetn && go && cmd == 4'h3;
      keypad_req <= aresetn && go && cmd == 4'h4;
      watchdog_timeout <= aresetn && go && cmd == 4'h5;
   end
   // unit requests held until the vector is taken
   always_ff @(posedge aclk) begin
      if (!aresetn || vector_valid) begin
         unit_irq <= '0;
      end else begin
         unit_irq <= lpw_pkg::lpw_irq_t'(unit_irq | irq_sel);
      end
   end
endmodule

/* bench/testbench.sv */
// testbench: wake sources, gating, recovery and register access
`timescale 1ns/1ps
module testbench;
   logic aclk, aresetn, go, rst_pin_n, irq_a, irq_b, sup_low, ssu_seen;
   logic awv, wv, br, arv, rr, awr, wrd, bv, arr, rv, ww, sw, brk, kp, wd;
   logic sys_reset, vector_valid;
   logic [3:0] cmd, awa, ara, wst;
   logic [11:0] irq_sel;
   logic [31:0] wdat, rdat, rd;
   logic [1:0] brs, rrs, rsp;
   logic [15:0] wake_vector;
   logic [15:0] q[$];
   logic [15:0] vt[12];
   logic [5:0] rnd;
   lpw_pkg::lpw_irq_t uirq;
   lpw_pkg::lpw_gate_t gate;
   int error_cnt = 0, tests_run = 0, seed = 32'h3bf01103, n, i;
   // short counts keep the run brief
   localparam int NF = 64;
   localparam int NS = 32;
   lpw_wake_ctrl #(.REC_FULL(NF), .REC_SHORT(NS)) lpw_wake_ctrl_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat),
      .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .reset_pin_n(rst_pin_n),
      .ext_interrupt_pin_first(irq_a), .ext_interrupt_pin_second(irq_b),
      .supply_low(sup_low), .wait_exec(ww), .stop_exec(sw),
      .break_req(brk), .watchdog_timeout(wd), .keypad_req(kp),
      .unit_irq(uirq), .gate(gate), .sys_reset(sys_reset),
      .vector_valid(vector_valid), .wake_vector(wake_vector));
   lpw_core_model lpw_core_model_inst (.aclk(aclk), .aresetn(aresetn),
      .go(go), .cmd(cmd), .irq_sel(irq_sel), .vector_valid(vector_valid),
      .wait_exec(ww), .stop_exec(sw), .break_req(brk), .keypad_req(kp),
      .watchdog_timeout(wd), .unit_irq(uirq));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      awa <= a;
      wdat <= d;
      {awv, wv, br} <= 3'b111;
      do @(posedge aclk); while (awr !== 1'b1);
      {awv, wv} <= 2'b00;
      do @(posedge aclk); while (bv !== 1'b1);
   endtask
   task automatic rdw(input logic [3:0] a);
      ara <= a;
      {arv, rr} <= 2'b11;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      rd = rdat;
      rsp = rrs;
   endtask
   // codes 7 and 8 pull the interrupt pins low instead
   task automatic cg(input logic [3:0] c, input logic [11:0] s);
      cmd <= c;
      irq_sel <= s;
      go <= 1'b1;
      irq_a <= c != 4'h7;
      irq_b <= c != 4'h8;
      @(posedge aclk);
      go <= 1'b0;
      irq_sel <= '0;
      @(posedge aclk);
   endtask
   // expected vector noted before the source fires
   task automatic wake(input logic [3:0] c, input logic [11:0] s,
                       input logic [15:0] v);
      q.push_back(v);
      cg(c, s);
      tick(4);
      n = 0;
      while (q.size() > 0 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk("wake_taken", 0, q.size());
   endtask
   task automatic gchk(input logic [7:0] e);
      tick(3);
      chk("gate", e, gate & 8'hf7);
   endtask
   task automatic rst_chk;
      n = 0;
      while (sys_reset !== 1'b1 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      {rst_pin_n, sup_low} <= 2'b10;
      tick(6);
      chk("sys_reset", 1, n < 20);
      chk("reset_vector", lpw_pkg::VEC_RESET, wake_vector);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // processes
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (vector_valid === 1'b1 && q.size() > 0)
         chk("wake_vector", q.pop_front(), wake_vector);
   end
   always @(posedge aclk)
      ssu_seen <= !aresetn ? 1'b0 : ssu_seen | (gate.ssu_reset === 1'b1);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      tick(20000);
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      {aresetn, go, awv, wv, br, arv, rr, sup_low} = '0;
      {rst_pin_n, irq_a, irq_b, cmd, awa, ara, wdat, irq_sel} = {3'b111, 56'h0};
      wst = 4'hf;
      vt = '{lpw_pkg::VEC_ASU_ERR, lpw_pkg::VEC_ASU_RX, lpw_pkg::VEC_ASU_TX,
             lpw_pkg::VEC_SSU_RX, lpw_pkg::VEC_SSU_TX, lpw_pkg::VEC_TIM_CH0,
             lpw_pkg::VEC_TIM_CH1, lpw_pkg::VEC_TIM_CH2, lpw_pkg::VEC_TIM_CH3,
             lpw_pkg::VEC_TIM_OVF, lpw_pkg::VEC_DMA, lpw_pkg::VEC_PLL};
      tick(20);
      aresetn <= 1'b1;
      tick(3);
      chk("gate_reset", 8'hc2, gate);
      rnd = 6'($random(seed));
      wr(lpw_pkg::CTRL_OFFSET, {26'h0, rnd});
      rdw(lpw_pkg::CTRL_OFFSET);
      chk("ctrl", {26'h0, rnd}, rd);
      rdw(4'hc);
      chk("unmapped_resp", 2'b10, rsp);
      wr(lpw_pkg::CTRL_OFFSET, 32'h0);
      $display("test registers done");
      for (i = 0; i < 12; i++) begin
         cg(4'h1, 12'h0);
         gchk(8'h42);
         wake(4'h6, 12'(1 << i), vt[i]);
      end
      cg(4'h1, 12'h0);
      wake(4'h3, 12'h0, lpw_pkg::VEC_BREAK);
      cg(4'h1, 12'h0);
      wake(4'h4, 12'h0, lpw_pkg::VEC_KBD);
      cg(4'h1, 12'h0);
      wake(4'h8, 12'h0, lpw_pkg::VEC_EXT_INTERRUPT_PIN_SECOND);
      $display("test wait wakes done");
      wr(lpw_pkg::CTRL_OFFSET, 32'h0000_000e);
      cg(4'h2, 12'h0);
      cg(4'h6, 12'hfff);
      cg(4'h4, 12'h0);
      gchk(8'h37);
      wake(4'h3, 12'h0, lpw_pkg::VEC_BREAK);
      chk("full_rec", 1, n >= NF - 3 && n <= NF + 1);
      wr(lpw_pkg::CTRL_OFFSET, 32'h0000_0001);
      cg(4'h2, 12'h0);
      wake(4'h4, 12'h0, lpw_pkg::VEC_KBD);
      chk("short_rec", 1, n >= NS - 3 && n <= NS + 1);
      cg(4'h2, 12'h0);
      wake(4'h7, 12'h0, lpw_pkg::VEC_EXT_INTERRUPT_PIN_FIRST);
      $display("test stop wakes done");
      wr(lpw_pkg::CTRL_OFFSET, 32'h0000_000c);
      cg(4'h1, 12'h0);
      sup_low <= 1'b1;
      rst_chk;
      cg(4'h1, 12'h0);
      cg(4'h5, 12'h0);
      rst_chk;
      chk("ssu_reset_wait", 0, ssu_seen);
      cg(4'h2, 12'h0);
      rst_pin_n <= 1'b0;
      rst_chk;
      chk("ssu_reset_stop", 1, ssu_seen);
      rdw(lpw_pkg::STATUS_OFFSET);
      chk("status", 32'h0000_0007, rd);
      $display("test reset wakes done");
      tally_and_finish;
   end
endmodule
